// ==== lf_cpu_model.sv ====
// CPU side model: an APB master issuing register transfers.
// Assumes a slave answering with pready on the shared clock.
module lf_cpu_model (
  input wire clock_i,
  input wire [31:0] prdata_i,
  input wire pready_i,
  input wire pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [11:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Transfer task
  // ****************************************
  initial begin
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
  end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge clock_i);
    psel_o <= 1'h1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    pstrb_o <= s;
    @(posedge clock_i);
    penable_o <= 1'h1;
    @(posedge clock_i);
    while (pready_i !== 1'h1) @(posedge clock_i);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'h0;
    penable_o <= 1'h0;
  endtask
endmodule // lf_cpu_model

// ==== lf_input_sync.v ====
// Three-stage synchroniser with agreement of the last two stages.
// Assumes an asynchronous input and a single system clock.
module lf_input_sync (
  input wire clock_i,
  input wire arst_n_i,
  input wire async_i,
  output reg level_o
);
  reg stage1;
  reg stage2;
  reg stage3;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_o <= stage3;
      end
    end
  end
endmodule // lf_input_sync

// ==== lf_irq_consts.vh ====
// Constants for the low-frequency receiver interrupt and decode control.
// Assumes inclusion by bare name from the design files.
`ifndef LF_IRQ_CONSTS_VH
`define LF_IRQ_CONSTS_VH
// ********************************
// Register indices and byte addresses
// ********************************
`define CTL_INDEX 8'h23
`define STATUS_INDEX 8'h24
`define CTL_ADDR 12'h08c
`define STATUS_ADDR 12'h090
`define INFO_ADDR 12'h094
`define ADDR_W 12
// ********************************
// Control fields and reset
// ********************************
`define CTL_RESET 8'h0c
`define BIT_DR_IE 7
`define BIT_ER_IE 6
`define BIT_CD_IE 5
`define BIT_ID_IE 4
`define BIT_DEC_EN 3
`define BIT_VAL_EN 2
// ********************************
// Status fields
// ********************************
`define BIT_DR_F 7
`define BIT_ER_F 6
`define BIT_CD_F 5
`define BIT_ID_F 4
`define BIT_OV_F 3
`define BIT_EOM_F 2
`define BIT_ACK 0
// ********************************
// Timeout in oscillator ticks
// ********************************
`define OSC_HZ 32000
`define TO_MS_1 8
`define TO_MS_2 24
`define TO_MS_3 48
`define TO_TICKS_1 (`OSC_HZ / 1000 * `TO_MS_1)
`define TO_TICKS_2 (`OSC_HZ / 1000 * `TO_MS_2)
`define TO_TICKS_3 (`OSC_HZ / 1000 * `TO_MS_3)
`define TO_W 12
`endif

// ==== lf_irq_properties.sv ====
// Port checker for the receiver interrupt and decode control.
// Assumes binding to lf_receiver_irq_control on one clock.
`include "lf_irq_consts.vh"
module lf_irq_chk (
  input wire clock_i,
  input wire arst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire data_ready_evt_i,
  input wire receive_error_evt_i,
  input wire carrier_detect_evt_i,
  input wire id_match_evt_i,
  input wire sync_found_i,
  input wire sync_search_i,
  input wire irq_o,
  input wire digital_decoder_enable_o,
  input wire carrier_validation_enable_o,
  input wire receiver_power_off_o
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  wire acc = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
  wire wr_ctl = acc && (paddr_i == `CTL_ADDR);
  wire wr_ack = acc && (paddr_i == `STATUS_ADDR) && pwdata_i[0];
  wire evt = data_ready_evt_i || receive_error_evt_i ||
    carrier_detect_evt_i || id_match_evt_i;
  wire unmapped = (paddr_i != `CTL_ADDR) && (paddr_i != `STATUS_ADDR) &&
    (paddr_i != `INFO_ADDR);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  property p_answer; psel_i && !penable_i |=> pready_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_one; pready_o |=> !pready_o; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pready_o |-> pslverr_o == unmapped; endproperty
  a_err: assert property (p_err) else $error("bad slave error");
  property p_upper;
    pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_ackrd;
    pready_o && !pwrite_i && paddr_i == `STATUS_ADDR |-> prdata_o[1:0] == 2'h0;
  endproperty
  a_ackrd: assert property (p_ackrd) else $error("ack reads one");
  property p_ack; wr_ack && !evt |=> ##1 !irq_o; endproperty
  a_ack: assert property (p_ack) else $error("irq after ack");
  property p_dec;
    $changed(digital_decoder_enable_o) |-> $past(wr_ctl, 2);
  endproperty
  a_dec: assert property (p_dec) else $error("decoder moved");
  property p_val;
    $changed(carrier_validation_enable_o) |-> $past(wr_ctl, 2);
  endproperty
  a_val: assert property (p_val) else $error("validation moved");
  property p_pwr;
    $rose(receiver_power_off_o) |->
      $past(sync_search_i) && !$past(sync_found_i);
  endproperty
  a_pwr: assert property (p_pwr) else $error("bad power off");
  property p_irq_src;
    $rose(irq_o) |-> $past(evt, 2) || $past(wr_ctl, 2);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq from nowhere");
endmodule // lf_irq_chk
bind lf_receiver_irq_control lf_irq_chk u_chk (.clock_i, .arst_n_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
  .pslverr_o, .data_ready_evt_i, .receive_error_evt_i, .carrier_detect_evt_i,
  .id_match_evt_i, .sync_found_i, .sync_search_i, .irq_o,
  .digital_decoder_enable_o, .carrier_validation_enable_o,
  .receiver_power_off_o);

// ==== lf_receiver_irq_control.v ====
// Interrupt enable and decode control of the low-frequency receiver.
// Assumes an APB master on clock_i and receiver event pulses on clock_i;
// the oscillator and raw detector arrive asynchronously.
// Overview of operation
// - Any set flag whose enable is set raises the request; only carrier detect is masked.
// - Bit 7 enables a request while the data-ready flag is set.
// - Bit 6 enables a request while the receive-error flag is set.
// - Bit 5 enables the carrier-detect request, off in data mode if decoding.
// - Bit 4 enables a request while the ID-match flag is set.
// - Bit 3 clear disables decoding and blocks data, error and ID flags.
// - Bit 2 runs or stops carrier validation.
// - The two-bit field picks no limit, 8, 24 or 48 ms of SYNC search.
// - SYNC not found in time in data mode, while decoding, powers the receiver off.
// - The search is timed by the receiver oscillator.
// - Reset returns the timeout field to no limit.
// - Writing one to acknowledge clears all six flags; it reads zero.
// - Carrier mode one means carrier detect, zero means data receive.
`include "lf_irq_consts.vh"
module lf_receiver_irq_control (
  input wire clock_i,
  input wire arst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [`ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire data_ready_evt_i,
  input wire receive_error_evt_i,
  input wire carrier_detect_evt_i,
  input wire id_match_evt_i,
  input wire overflow_evt_i,
  input wire eom_evt_i,
  input wire sync_found_i,
  input wire sync_search_i,
  input wire carrier_mode_select_i,
  input wire receiver_internal_oscillator_i,
  input wire raw_detector_output_i,
  output reg irq_o,
  output reg digital_decoder_enable_o,
  output reg carrier_validation_enable_o,
  output reg receiver_power_off_o
);
  // ********************************
  // Declarations
  // ********************************
  reg [7:0] ctl;
  reg [7:0] flags;
  reg [7:0] next_flags;
  reg osc_prev;
  reg search;
  wire osc_level;
  wire raw_level;
  wire expired;
  wire [1:0] sync_search_timeout_sel;
  wire osc_tick;
  wire setup;
  wire wr_ctl;
  wire wr_status;
  wire ack;
  wire decoding;
  wire cd_gate;
  wire irq_next;
  reg [31:0] rd_data;
  reg rd_err;

  function automatic [7:0] byte_merge;
    input [7:0] old_value;
    input [7:0] new_value;
    input strobe;
    begin
      byte_merge = strobe ? new_value : old_value;
    end
  endfunction

  // ********************************
  // Input synchronisers
  // ********************************
  lf_input_sync osc_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .async_i(receiver_internal_oscillator_i),
    .level_o(osc_level)
  );
  lf_input_sync raw_sync (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .async_i(raw_detector_output_i),
    .level_o(raw_level)
  );

  // ********************************
  // Bus decode
  // ********************************
  assign setup = psel_i && !penable_i;
  // Writes land at the access edge on which pready is seen high
  assign wr_ctl = psel_i && penable_i && pwrite_i && pready_o &&
    paddr_i == `CTL_ADDR;
  assign wr_status = psel_i && penable_i && pwrite_i && pready_o &&
    paddr_i == `STATUS_ADDR;
  assign ack = wr_status && pstrb_i[0] && pwdata_i[`BIT_ACK];
  assign sync_search_timeout_sel = ctl[1:0];

  // ********************************
  // Control register
  // ********************************
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl <= `CTL_RESET;
    end else if (wr_ctl) begin
      ctl <= byte_merge(ctl, pwdata_i[7:0], pstrb_i[0]);
    end
  end

  // ********************************
  // Status flags
  // ********************************
  assign decoding = ctl[`BIT_DEC_EN];
  always @* begin
    next_flags = flags;
    if (ack) begin
      next_flags = 8'h00;
    end
    // Set wins over acknowledge in the same cycle
    if (data_ready_evt_i && decoding) begin
      next_flags[`BIT_DR_F] = 1'b1;
    end
    if (receive_error_evt_i && decoding && !carrier_mode_select_i) begin
      next_flags[`BIT_ER_F] = 1'b1;
    end
    if (carrier_detect_evt_i) begin
      next_flags[`BIT_CD_F] = 1'b1;
    end
    if (id_match_evt_i && decoding && !carrier_mode_select_i) begin
      next_flags[`BIT_ID_F] = 1'b1;
    end
    if (overflow_evt_i && decoding && !carrier_mode_select_i) begin
      next_flags[`BIT_OV_F] = 1'b1;
    end
    if (eom_evt_i && decoding && !carrier_mode_select_i) begin
      next_flags[`BIT_EOM_F] = 1'b1;
    end
    next_flags[1:0] = 2'b00;
  end
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags <= 8'h00;
    end else begin
      flags <= next_flags;
    end
  end

  // ********************************
  // Interrupt request
  // ********************************
  assign cd_gate = carrier_mode_select_i || !decoding;
  assign irq_next =
    (flags[`BIT_DR_F] && ctl[`BIT_DR_IE]) ||
    (flags[`BIT_ER_F] && ctl[`BIT_ER_IE]) ||
    (flags[`BIT_CD_F] && ctl[`BIT_CD_IE] && cd_gate) ||
    (flags[`BIT_ID_F] && ctl[`BIT_ID_IE]);
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_next;
    end
  end

  // ********************************
  // SYNC search timeout
  // ********************************
  assign osc_tick = osc_level && !osc_prev;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_prev <= 1'b0;
      search <= 1'b0;
      receiver_power_off_o <= 1'b0;
      digital_decoder_enable_o <= 1'b1;
      carrier_validation_enable_o <= 1'b1;
    end else begin
      osc_prev <= osc_level;
      search <= sync_search_i && !sync_found_i && !carrier_mode_select_i &&
        decoding;
      digital_decoder_enable_o <= ctl[`BIT_DEC_EN];
      carrier_validation_enable_o <= ctl[`BIT_VAL_EN];
      if (expired) begin
        receiver_power_off_o <= 1'b1;
      end else if (sync_search_i && !search) begin
        receiver_power_off_o <= 1'b0;
      end
    end
  end
  lf_sync_timer sync_timer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .sel_i(sync_search_timeout_sel),
    .search_i(search),
    .tick_i(osc_tick),
    .expired_o(expired)
  );

  // ********************************
  // Read path and APB answer
  // ********************************
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr_i)
      `CTL_ADDR: rd_data[7:0] = ctl;
      `STATUS_ADDR: rd_data[7:0] = flags;
      `INFO_ADDR: rd_data[0] = raw_level;
      default: rd_err = 1'b1;
    endcase
  end
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (setup) begin
      pready_o <= 1'b1;
      pslverr_o <= rd_err;
      prdata_o <= pwrite_i ? 32'h0000_0000 : rd_data;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end
endmodule // lf_receiver_irq_control

// ==== lf_receiver_irq_control_tb.sv ====
// Self-checking bench for the receiver interrupt and decode control.
// Assumes the CPU model and the bound port checker.
`include "lf_irq_consts.vh"
module lf_receiver_irq_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic [5:0] ev = '0;
  logic mode = 1'h0, srch = 1'h0, fnd = 1'h0, osc = 1'h0, raw = 1'h0;
  wire psel, pen, pwr, prdy, perr, irq, dec, val, pw;
  wire [11:0] pa;
  wire [31:0] pwd, prd;
  wire [3:0] ps;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0, checked = 0, cyc = 0, n;
  lf_receiver_irq_control u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .pstrb_i(ps), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .data_ready_evt_i(ev[0]), .receive_error_evt_i(ev[1]),
    .carrier_detect_evt_i(ev[2]), .id_match_evt_i(ev[3]),
    .overflow_evt_i(ev[4]), .eom_evt_i(ev[5]), .sync_found_i(fnd),
    .sync_search_i(srch), .carrier_mode_select_i(mode),
    .receiver_internal_oscillator_i(osc), .raw_detector_output_i(raw),
    .irq_o(irq), .digital_decoder_enable_o(dec),
    .carrier_validation_enable_o(val), .receiver_power_off_o(pw));
  lf_cpu_model u_cpu (.clock_i(clock_i), .prdata_i(prd), .pready_i(prdy),
    .pslverr_i(perr), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(pa), .pwdata_o(pwd), .pstrb_o(ps));
  // ****************************************
  // Helpers
  // ****************************************
  initial forever #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end
  task stop_test();
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_cpu.xfer(1'h1, a, d, 4'hf, rdat, rerr);
    repeat (3) @(posedge clock_i);
  endtask
  task rd(input logic [11:0] a);
    u_cpu.xfer(1'h0, a, 32'h0000_0000, 4'h0, rdat, rerr);
  endtask
  task pulse(input int i);
    @(posedge clock_i);
    ev[i] <= 1'h1;
    @(posedge clock_i);
    ev <= '0;
    repeat (3) @(posedge clock_i);
  endtask
  task tick(input int k);
    repeat (k) begin
      repeat (4) @(posedge clock_i);
      osc <= 1'h1;
      repeat (4) @(posedge clock_i);
      osc <= 1'h0;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset();
    rd(`CTL_ADDR);
    chk(rdat, 32'h0000_000c);
    chk({dec, val, irq}, 32'h0000_0006);
    rd(`STATUS_ADDR);
    chk(rdat, 32'h0000_0000);
  endtask
  task t_refused();
    u_cpu.xfer(1'h1, 12'h0fc, 32'hffff_ffff, 4'hf, rdat, rerr);
    chk(rerr, 32'h0000_0001);
    u_cpu.xfer(1'h1, `CTL_ADDR, 32'h0000_00f3, 4'he, rdat, rerr);
    rd(12'h0fc);
    chk({rerr, rdat[30:0]}, 32'h8000_0000);
    rd(`CTL_ADDR);
    chk(rdat, 32'h0000_000c);
  endtask
  task t_flags();
    for (int i = 0; i < 4; i++) begin
      mode <= (i == 2);
      wr(`STATUS_ADDR, 32'h0000_0001);
      pulse(i);
      chk(irq, 32'h0000_0000);
      rd(`STATUS_ADDR);
      chk(rdat, 32'h0000_0080 >> i);
      wr(`CTL_ADDR, 32'h0000_000c | (32'h0000_0080 >> i));
      chk(irq, 32'h0000_0001);
      wr(`CTL_ADDR, 32'h0000_000c);
      chk(irq, 32'h0000_0000);
      wr(`CTL_ADDR, 32'h0000_000c | (32'h0000_0080 >> i));
      chk(irq, 32'h0000_0001);
      wr(`STATUS_ADDR, 32'h0000_0001);
      chk(irq, 32'h0000_0000);
    end
    mode <= 1'h0;
    pulse(4);
    pulse(5);
    rd(`STATUS_ADDR);
    chk(rdat, 32'h0000_000c);
    wr(`STATUS_ADDR, 32'h0000_0001);
    rd(`STATUS_ADDR);
    chk(rdat, 32'h0000_0000);
  endtask
  task t_decode();
    wr(`CTL_ADDR, 32'h0000_002c);
    pulse(2);
    chk(irq, 32'h0000_0000);
    wr(`CTL_ADDR, 32'h0000_0024);
    chk({irq, dec}, 32'h0000_0002);
    wr(`STATUS_ADDR, 32'h0000_0001);
    pulse(0);
    pulse(1);
    pulse(3);
    rd(`STATUS_ADDR);
    chk(rdat, 32'h0000_0000);
    wr(`CTL_ADDR, 32'h0000_0008);
    chk({dec, val}, 32'h0000_0002);
    wr(`CTL_ADDR, 32'h0000_000c);
    for (int v = 1; v >= 0; v--) begin
      raw <= v[0];
      repeat (6) @(posedge clock_i);
      rd(`INFO_ADDR);
      chk(rdat, v);
    end
  endtask
  task t_timeout();
    for (int c = 0; c < 4; c++) begin
      wr(`CTL_ADDR, 32'h0000_000c | c);
      srch <= 1'h0;
      repeat (3) @(posedge clock_i);
      srch <= 1'h1;
      if (c == 0) begin
        tick(300);
        chk(pw, 32'h0000_0000);
      end else begin
        n = (c == 1) ? 256 : (c == 2) ? 768 : 1536;
        repeat (2000) @(posedge clock_i);
        chk(pw, 32'h0000_0000);
        tick(n - 6);
        chk(pw, 32'h0000_0000);
        tick(12);
        chk(pw, 32'h0000_0001);
      end
    end
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    arst_n_i <= 1'h1;
    t_reset();
    t_refused();
    t_flags();
    t_decode();
    t_timeout();
    stop_test();
  end
endmodule // lf_receiver_irq_control_tb

// ==== lf_sync_timer.v ====
// SYNC search timer, counting receiver oscillator ticks.
// Assumes tick_i is a one-cycle pulse per synchronised oscillator rising edge.
`include "lf_irq_consts.vh"
module lf_sync_timer (
  input wire clock_i,
  input wire arst_n_i,
  input wire [1:0] sel_i,
  input wire search_i,
  input wire tick_i,
  output reg expired_o
);
  reg [`TO_W-1:0] count;
  reg [`TO_W-1:0] limit;
  wire [31:0] ticks_1 = `TO_TICKS_1;
  wire [31:0] ticks_2 = `TO_TICKS_2;
  wire [31:0] ticks_3 = `TO_TICKS_3;
  always @* begin
    case (sel_i)
      2'd1: limit = ticks_1[`TO_W-1:0];
      2'd2: limit = ticks_2[`TO_W-1:0];
      2'd3: limit = ticks_3[`TO_W-1:0];
      default: limit = {`TO_W{1'b0}};
    endcase
  end
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= {`TO_W{1'b0}};
      expired_o <= 1'b0;
    end else if (!search_i || sel_i == 2'd0) begin
      count <= {`TO_W{1'b0}};
      expired_o <= 1'b0;
    end else if (tick_i && !expired_o) begin
      count <= count + {{(`TO_W-1){1'b0}}, 1'b1};
      if (count + {{(`TO_W-1){1'b0}}, 1'b1} >= limit) begin
        expired_o <= 1'b1;
      end
    end
  end
endmodule // lf_sync_timer
